// [src/sck_rate_gen.sv]
/*
 * Master serial clock rate generator: one pulse per half serial clock period.
 * Assumes the timer-two tick is a one-cycle pulse on the system clock.
 */
`timescale 1ns/1ps
module sck_rate_gen
    import spi_port_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [MODE_W-1:0] mode_i,
    input wire logic [DATA_W-1:0] reload_i,
    input wire logic t2_tick_i,
    output logic half_tick_o
);

    logic [HALF_W-1:0] cnt;
    logic [HALF_W-1:0] next_cnt;
    logic [HALF_W-1:0] half;

    always_comb begin
        case (mode_i)
            MODE_DIV16: half = HALF_DIV16;
            MODE_DIV64: half = HALF_DIV64;
            // Period of four times reload plus one system clocks
            MODE_RELOAD: half = {1'b0, reload_i, 1'b0} + HALF_RELOAD_ADD;
            default: half = HALF_DIV4;
        endcase
        if (mode_i == MODE_TMR2) begin
            half_tick_o = run_i & t2_tick_i;
        end else begin
            half_tick_o = run_i & (cnt == half - HALF_ONE);
        end
        if (!run_i || half_tick_o) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + HALF_ONE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule : sck_rate_gen

// [src/spi_port_pkg.sv]
/*
 * Shared constants and carriers of the synchronous serial port, SPI mode.
 * Assumes a single system clock that also times master mode.
 */
package spi_port_pkg;

    localparam int DATA_W = 8;
    localparam int MODE_W = 4;
    localparam int HALF_W = 10;
    localparam int EDGE_W = 4;
    localparam int STATUS_RSVD_W = 5;

    // Port mode select codes
    localparam logic [MODE_W-1:0] MODE_DIV4 = 4'h0;
    localparam logic [MODE_W-1:0] MODE_DIV16 = 4'h1;
    localparam logic [MODE_W-1:0] MODE_DIV64 = 4'h2;
    localparam logic [MODE_W-1:0] MODE_TMR2 = 4'h3;
    localparam logic [MODE_W-1:0] MODE_SLAVE_SS = 4'h4;
    localparam logic [MODE_W-1:0] MODE_SLAVE = 4'h5;
    localparam logic [MODE_W-1:0] MODE_RELOAD = 4'ha;

    // System clocks per half serial clock period
    localparam logic [HALF_W-1:0] HALF_DIV4 = 10'h002;
    localparam logic [HALF_W-1:0] HALF_DIV16 = 10'h008;
    localparam logic [HALF_W-1:0] HALF_DIV64 = 10'h020;
    localparam logic [HALF_W-1:0] HALF_ONE = 10'h001;
    localparam logic [HALF_W-1:0] HALF_RELOAD_ADD = 10'h002;

    // Sixteen clock transitions make one byte
    localparam logic [EDGE_W-1:0] EDGE_FIRST = 4'h0;
    localparam logic [EDGE_W-1:0] EDGE_LAST = 4'hf;
    localparam logic [EDGE_W-1:0] EDGE_STEP = 4'h1;

    typedef enum {ST_IDLE, ST_XFER} xfer_state_e;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic edge_sel;
        logic sample_phase;
        logic overwrite_en;
        logic [MODE_W-1:0] mode;
    } port_ctrl_s;

    typedef struct packed {
        logic write_collision;
        logic irq_flag;
        logic buffer_full;
        logic busy;
    } port_flags_s;

endpackage : spi_port_pkg

// [src/sync_serial_spi_port.sv]
/*
 * SPI mode of the synchronous serial port: shift engine, receive buffer,
 * flags and pin control. Assumes software drives the control inputs as
 * levels and buffer strobes as one-cycle pulses on sys_clk_i; pin inputs
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
//
// Function
// - Eight-bit MSB-first shift; full byte sets flags
// - Buffer write loads buffer and shifter together
// - Write during transfer discarded, collision flag set
// - Buffer read clears full flag; double-buffered
// - Enable bit hands pins to serial port
// - Master transfer starts on buffer write
// - Receive-only master still buffers each byte
// - Master rate: Fosc/4,16,64, timer/2, reload
// - Reload divider value from address register
// - Polarity sets idle level, edge bit output edge
// - Edge bit set: data valid before first edge
// - Sample phase picks middle or end sampling
// - Slave shifts on external clock, flags last bit
// - Slave keeps shifting during sleep, wakes device
// - Daisy-chain slave echoes received bits next group
// - Overwrite enable accepts data despite unread byte
// - Status low six read-only, shifter hidden
// - Slave-select high releases data-out two clocks late
// - Port reset forces bit counter to zero
// - Shift out one edge, latch on opposite
module sync_serial_spi_port
    import spi_port_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire port_ctrl_s ctrl_i,
    input wire logic [DATA_W-1:0] reload_i,
    input wire logic t2_tick_i,
    input wire logic sleep_i,
    input wire logic irq_enable_i,
    input wire logic buf_wr_i,
    input wire logic [DATA_W-1:0] buf_wdata_i,
    input wire logic buf_rd_i,
    input wire logic irq_clr_i,
    input wire logic write_collision_flag_clr_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic ss_n_i,
    output logic sck_o,
    output logic sck_oe_o,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic [DATA_W-1:0] buf_rdata_o,
    output port_flags_s flags_o,
    output logic [DATA_W-1:0] status_reg_o,
    output logic wake_o
);

    localparam int PIN_N = 3;

    logic rst_meta;
    logic rst_n;
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic sck_s;
    logic sdi_s;
    logic ss_s;
    logic sck_d;

    xfer_state_e state, next_state;
    logic [DATA_W-1:0] shift_register, next_shift_register;
    logic [DATA_W-1:0] data_buffer, next_data_buffer;
    logic [EDGE_W-1:0] edge_cnt, next_edge_cnt;
    logic in_bit, next_in_bit;
    logic sck_lvl, next_sck_lvl;
    logic buffer_full_flag, next_buffer_full_flag;
    logic serial_irq_flag, next_serial_irq_flag;
    logic write_collision_flag, next_write_collision_flag;

    logic master;
    logic ss_mode;
    logic port_rst;
    logic busy;
    logic half_tick;
    logic edge_ev;
    logic sample_edge;
    logic done;
    logic [DATA_W-1:0] rx_byte;

    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign pin_raw = {sck_i, sdi_i, ss_n_i};

    // No reset: the copies track the pins through reset, so its release
    // cannot fake a clock edge whatever the idle level
    generate
        for (genvar i = 0; i < PIN_N; i++) begin : g_pin_sync
            always_ff @(posedge sys_clk_i) begin
                pin_meta[i] <= pin_raw[i];
                pin_sync[i] <= pin_meta[i];
            end
        end
    endgenerate

    assign sck_s = pin_sync[2];
    assign sdi_s = pin_sync[1];
    assign ss_s = pin_sync[0];

    always_ff @(posedge sys_clk_i) begin
        sck_d <= sck_s;
    end

    assign master = (ctrl_i.mode != MODE_SLAVE_SS)
        && (ctrl_i.mode != MODE_SLAVE);
    assign ss_mode = ctrl_i.mode == MODE_SLAVE_SS;
    assign port_rst = !ctrl_i.enable || (ss_mode && ss_s);
    assign busy = state == ST_XFER;

    // Master clock stops in sleep; the slave keeps running on the pin
    sck_rate_gen u_rate (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .run_i(master && busy && !sleep_i && !port_rst),
        .mode_i(ctrl_i.mode),
        .reload_i(reload_i),
        .t2_tick_i(t2_tick_i),
        .half_tick_o(half_tick)
    );

    // The master counts its own generated edges as the port clock
    always_comb begin
        if (master) begin
            edge_ev = busy && half_tick && !port_rst;
        end else begin
            edge_ev = (sck_s != sck_d) && !port_rst;
        end
        // Edge bit set: first transition samples, data already out
        sample_edge = edge_cnt[0] != ctrl_i.edge_sel;
        if (ctrl_i.edge_sel && !ctrl_i.sample_phase) begin
            rx_byte = {shift_register[DATA_W-2:0], in_bit};
        end else begin
            rx_byte = {shift_register[DATA_W-2:0], sdi_s};
        end
    end

    always_comb begin
        next_state = state;
        next_shift_register = shift_register;
        next_data_buffer = data_buffer;
        next_edge_cnt = edge_cnt;
        next_in_bit = in_bit;
        next_sck_lvl = sck_lvl;
        next_buffer_full_flag = buffer_full_flag;
        next_serial_irq_flag = serial_irq_flag;
        next_write_collision_flag = write_collision_flag;
        done = 1'b0;
        // Clears first so that a same-cycle set wins
        if (buf_rd_i) begin
            next_buffer_full_flag = 1'b0;
        end
        if (irq_clr_i) begin
            next_serial_irq_flag = 1'b0;
        end
        if (write_collision_flag_clr_i) begin
            next_write_collision_flag = 1'b0;
        end
        if (port_rst) begin
            next_state = ST_IDLE;
            next_edge_cnt = EDGE_FIRST;
            next_sck_lvl = ctrl_i.polarity;
        end else begin
            if (buf_wr_i && (busy || write_collision_flag
                    || (!master && edge_ev))) begin
                next_write_collision_flag = 1'b1;
            end else if (buf_wr_i) begin
                next_data_buffer = buf_wdata_i;
                next_shift_register = buf_wdata_i;
                if (master) begin
                    next_state = ST_XFER;
                end
            end
            if (!busy && master) begin
                next_sck_lvl = ctrl_i.polarity;
            end
            if (edge_ev) begin
                next_state = ST_XFER;
                next_edge_cnt = edge_cnt + EDGE_STEP;
                if (master) begin
                    next_sck_lvl = !sck_lvl;
                end
                if (edge_cnt == EDGE_LAST) begin
                    done = 1'b1;
                end else if (sample_edge) begin
                    next_in_bit = sdi_s;
                end else if (edge_cnt != EDGE_FIRST) begin
                    // Received bits walk out again: daisy-chain echo
                    next_shift_register = {shift_register[DATA_W-2:0],
                        ctrl_i.sample_phase ? sdi_s : in_bit};
                end
            end
            if (done) begin
                next_shift_register = rx_byte;
                next_state = ST_IDLE;
                next_edge_cnt = EDGE_FIRST;
                next_serial_irq_flag = 1'b1;
                // Unread byte kept unless overwrite is enabled
                if (!buffer_full_flag || buf_rd_i || ctrl_i.overwrite_en) begin
                    next_data_buffer = rx_byte;
                    next_buffer_full_flag = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            shift_register <= '0;
            data_buffer <= '0;
            edge_cnt <= EDGE_FIRST;
            in_bit <= 1'b0;
            sck_lvl <= 1'b0;
            buffer_full_flag <= 1'b0;
            serial_irq_flag <= 1'b0;
            write_collision_flag <= 1'b0;
        end else begin
            state <= next_state;
            shift_register <= next_shift_register;
            data_buffer <= next_data_buffer;
            edge_cnt <= next_edge_cnt;
            in_bit <= next_in_bit;
            sck_lvl <= next_sck_lvl;
            buffer_full_flag <= next_buffer_full_flag;
            serial_irq_flag <= next_serial_irq_flag;
            write_collision_flag <= next_write_collision_flag;
        end
    end

    // Pins belong to the port only while enabled
    assign sck_o = sck_lvl;
    assign sck_oe_o = ctrl_i.enable && master;
    assign sdo_o = shift_register[DATA_W-1];
    // Release follows the synchronised select, two clocks late
    assign sdo_oe_o = ctrl_i.enable && !(ss_mode && ss_s);
    assign buf_rdata_o = data_buffer;
    assign flags_o = '{write_collision: write_collision_flag,
        irq_flag: serial_irq_flag, buffer_full: buffer_full_flag,
        busy: busy};
    // Upper two bits mirror software settings; the rest are status
    assign status_reg_o = {ctrl_i.sample_phase, ctrl_i.edge_sel,
        {STATUS_RSVD_W{1'b0}}, buffer_full_flag};
    assign wake_o = serial_irq_flag && irq_enable_i;

    a_write_collision_flag_on_busy: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        buf_wr_i && busy && !port_rst && !done |=> write_collision_flag
            && data_buffer == $past(data_buffer))
        else $error("write during transfer not flagged");

    a_write_loads: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        buf_wr_i && !busy && !write_collision_flag && !port_rst
            && !edge_ev
        |=> data_buffer == $past(buf_wdata_i)
            && shift_register == $past(buf_wdata_i))
        else $error("buffer write not loaded into both registers");

    a_master_start: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        master && buf_wr_i && !busy && !write_collision_flag && !port_rst
        |=> busy ##0 sdo_o == $past(buf_wdata_i[DATA_W-1]))
        else $error("master did not start with the msb out");

    a_read_clears: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        buf_rd_i && !done |=> !buffer_full_flag)
        else $error("buffer read left full flag set");

    a_byte_done: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        done && !buffer_full_flag |=> buffer_full_flag && serial_irq_flag
            && data_buffer == shift_register && !busy)
        else $error("completed byte not buffered");

    a_ss_release: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        ss_mode && ss_s |-> !sdo_oe_o ##1 edge_cnt == EDGE_FIRST)
        else $error("slave select high did not release data out");

    a_disable_cnt: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        !ctrl_i.enable |=> edge_cnt == EDGE_FIRST && !busy)
        else $error("disable did not clear bit counter");

    a_sck_idle: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        master && !busy && $stable(ctrl_i.polarity)
            && $past(!busy) |-> sck_o == ctrl_i.polarity)
        else $error("master clock not at idle level");

    a_keep_unread: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        done && buffer_full_flag && !buf_rd_i && !ctrl_i.overwrite_en
        |=> data_buffer == $past(data_buffer) && serial_irq_flag)
        else $error("unread byte overwritten");

endmodule : sync_serial_spi_port

// [tb/spi_far_end.sv]
/* Far-side SPI peer: slave while the port is master, clock source while
   the port is slave. Assumes polarity 0 and edge select 0 framing. */
`timescale 1ns/1ps
module spi_far_end (
    input wire logic sys_clk_i,
    input wire logic bus_sck_i,
    input wire logic from_port_i,
    output logic to_port_o,
    output logic own_sck_o
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic seen = 1'b0;
    int rise_n = 0;

    initial own_sck_o = 1'b0;
    assign to_port_o = tx[7];
    // Copied mid-cycle: the port may move its data on a falling edge
    always @(negedge sys_clk_i) seen <= from_port_i;
    always @(negedge bus_sck_i) rx <= {rx[6:0], seen};
    // Msb already out, so the first rising edge of a byte shifts nothing
    // Fill with a changing bit so stale data never looks valid
    always @(posedge bus_sck_i) begin
        if (rise_n != 0) tx <= {tx[6:0], ~tx[0]};
        rise_n <= rise_n + 1;
    end

    task load(input logic [7:0] b);
        tx = b;
        rise_n = 0;
    endtask : load

    // Four system clocks per level so each edge survives the synchroniser
    task clock_bits(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (4) @(negedge sys_clk_i);
            own_sck_o = ~own_sck_o;
        end
    endtask : clock_bits
endmodule : spi_far_end

// [tb/tb.sv]
/* Self-checking bench of the SPI port: master, rates, slave, select.
   Assumes the far-side peer model and the design package. */
`timescale 1ns/1ps
module tb;
    import spi_port_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    port_ctrl_s ctrl = '0;
    logic [7:0] reload = 8'h05;
    logic t2_tick = 1'b0;
    logic sleep = 1'b0;
    logic irq_en = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic irq_clr = 1'b0;
    logic write_collision_flag_clr = 1'b0;
    logic ss_n = 1'b1;
    logic sdo_hold = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic sck_out, sck_oe, sdo_out, sdo_oe, wake, far_sck, far_dout;
    logic bus_sck, sdo_line;
    logic [7:0] rdata, status;
    port_flags_s flags;
    int error_cnt = 0;
    int checks_done = 0;
    int tick_n = 0;

    initial forever #12.5 clk = ~clk;
    localparam int P_WR = 0;
    localparam int P_RD = 1;
    localparam int P_IRQ = 2;
    localparam int P_WRITE_COLLISION_FLAG = 3;

    assign bus_sck = sck_oe ? sck_out : far_sck;
    // A released data line shows the inverse of its last value
    always @(posedge clk) if (sdo_oe) sdo_hold <= ~sdo_out;
    assign sdo_line = sdo_oe ? sdo_out : sdo_hold;
    always @(negedge clk) begin
        tick_n <= (tick_n == 4) ? 0 : tick_n + 1;
        t2_tick <= (tick_n == 4);
    end

    sync_serial_spi_port DUT (
        .sys_clk_i(clk), .arst_n_i(arst_n), .ctrl_i(ctrl),
        .reload_i(reload), .t2_tick_i(t2_tick), .sleep_i(sleep),
        .irq_enable_i(irq_en), .buf_wr_i(wr), .buf_wdata_i(wdata),
        .buf_rd_i(rd), .irq_clr_i(irq_clr), .write_collision_flag_clr_i(write_collision_flag_clr),
        .sck_i(bus_sck), .sdi_i(far_dout), .ss_n_i(ss_n),
        .sck_o(sck_out), .sck_oe_o(sck_oe), .sdo_o(sdo_out),
        .sdo_oe_o(sdo_oe), .buf_rdata_o(rdata), .flags_o(flags),
        .status_reg_o(status), .wake_o(wake)
    );
    spi_far_end far (.sys_clk_i(clk), .bus_sck_i(bus_sck),
        .from_port_i(sdo_line), .to_port_o(far_dout),
        .own_sck_o(far_sck));

    task chk(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task set_strobe(input int which, input logic v);
        case (which)
            P_WR: wr = v;
            P_RD: rd = v;
            P_IRQ: irq_clr = v;
            default: write_collision_flag_clr = v;
        endcase
    endtask : set_strobe

    task pulse(input int which);
        @(negedge clk);
        set_strobe(which, 1'b1);
        @(negedge clk);
        set_strobe(which, 1'b0);
    endtask : pulse

    task wr_buf(input logic [7:0] b);
        wdata = b;
        pulse(P_WR);
    endtask : wr_buf

    // Control changes only while the port is disabled
    task cfg(input logic [8:0] c);
        @(negedge clk);
        ctrl.enable = 1'b0;
        @(negedge clk);
        ctrl = c;
        @(negedge clk);
        ctrl.enable = 1'b1;
        repeat (4) @(negedge clk);
    endtask : cfg

    task wait_idle;
        int n;
        n = 0;
        while (flags.busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("idle", {7'h0, flags.busy}, 8'h00);
        repeat (2) @(negedge clk);
    endtask : wait_idle

    task wait_tog(output int n);
        logic s;
        s = sck_out;
        n = 0;
        while (sck_out === s && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_tog

    task t_master;
        cfg({5'h00, MODE_DIV16});
        far.load(8'h3c);
        wr_buf(8'ha5);
        chk("busy", {7'h0, flags.busy}, 8'h01);
        chk("sdo msb", {7'h0, sdo_out}, 8'h01);
        wr_buf(8'hff);
        chk("write_collision_flag", {7'h0, flags.write_collision}, 8'h01);
        wait_idle;
        chk("rx", rdata, 8'h3c);
        chk("far rx", far.rx, 8'ha5);
        chk("irq bf", {6'h0, flags.irq_flag, flags.buffer_full},
            8'h03);
        chk("status", status, 8'h01);
        wr_buf(8'h11);
        chk("blocked", {7'h0, flags.busy}, 8'h00);
        pulse(P_WRITE_COLLISION_FLAG);
        pulse(P_RD);
        chk("bf clr", {7'h0, flags.buffer_full}, 8'h00);
        pulse(P_IRQ);
        far.load(8'he7);
        wr_buf(8'hc3);
        chk("restart", {6'h0, flags.write_collision, flags.busy},
            8'h01);
        wait_idle;
        chk("rx 2", rdata, 8'he7);
        chk("far rx 2", far.rx, 8'hc3);
    endtask : t_master

    task t_rates;
        logic [3:0] md [5];
        int hv [5];
        int n;
        md = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TMR2, MODE_RELOAD};
        reload = 8'h09;
        // Tick every fifth cycle; reload 9 gives 2 * (9 + 1)
        hv = '{2, 8, 32, 5, 20};
        for (int i = 0; i < 5; i++) begin
            cfg({5'h00, md[i]});
            wr_buf(8'h00);
            wait_tog(n);
            wait_tog(n);
            chk("half", n[7:0], hv[i][7:0]);
            wait_idle;
            pulse(P_RD);
        end
    endtask : t_rates

    task t_slave;
        cfg({5'h01, MODE_SLAVE});
        pulse(P_IRQ);
        irq_en = 1'b1;
        sleep = 1'b1;
        wr_buf(8'h5a);
        far.load(8'h96);
        far.clock_bits(8);
        wait_idle;
        chk("slave rx", rdata, 8'h96);
        chk("slave tx", far.rx, 8'h5a);
        chk("wake", {7'h0, wake}, 8'h01);
        far.load(8'h00);
        far.clock_bits(8);
        wait_idle;
        chk("echo", far.rx, 8'h96);
        chk("overwrite", rdata, 8'h00);
        sleep = 1'b0;
        irq_en = 1'b0;
    endtask : t_slave

    task t_select;
        cfg({5'h00, MODE_SLAVE_SS});
        chk("oe off", {7'h0, sdo_oe}, 8'h00);
        ss_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("oe on", {7'h0, sdo_oe}, 8'h01);
        far.clock_bits(3);
        ss_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("oe mid", {7'h0, sdo_oe}, 8'h00);
        ss_n = 1'b0;
        repeat (4) @(negedge clk);
        pulse(P_RD);
        far.load(8'h69);
        far.clock_bits(8);
        wait_idle;
        chk("resync", rdata, 8'h69);
        ss_n = 1'b1;
    endtask : t_select

    task t_idle_level;
        pulse(P_RD);
        cfg({5'h0e, MODE_DIV4});
        chk("sck idle", {6'h0, sck_oe, sck_out}, 8'h03);
        chk("status", status, 8'hc0);
        wr_buf(8'h80);
        chk("sdo early", {7'h0, sdo_out}, 8'h01);
        wait_idle;
        ctrl.enable = 1'b0;
        @(negedge clk);
        chk("released", {6'h0, sck_oe, sdo_oe}, 8'h00);
    endtask : t_idle_level

    task final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // Whole run needs about 1750 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report;
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_master;
        t_rates;
        t_slave;
        t_select;
        t_idle_level;
        final_report;
    end
endmodule : tb
